// *** common/pspm_pkg.sv ***
// Constants and types shared by the switch power management block
package pspm_pkg;

    // Per-port register window: port p sits at p * PORT_STRIDE
    localparam logic [11:0] PORT_STRIDE = 12'h020;
    localparam logic [4:0] PM_CONTROL_STATUS_OFF = 5'h00;
    localparam logic [4:0] PME_RETRY_TIMER_OFF = 5'h04;
    localparam logic [4:0] TURNOFF_ACK_TIMER_OFF = 5'h08;
    localparam logic [4:0] PORT_STATE_OFF = 5'h0C;

    // Switch-wide registers
    localparam logic [11:0] SWITCH_CONTROL_OFF = 12'h100;
    localparam logic [11:0] BUDGET_CAP_HEADER_OFF = 12'h104;
    localparam logic [11:0] BUDGET_DATA_SELECT_OFF = 12'h108;
    localparam logic [11:0] BUDGET_DATA_OFF = 12'h10C;
    localparam logic [11:0] BUDGET_POWER_CAP_OFF = 12'h110;
    localparam logic [11:0] BUDGET_DATA_VALUE_BASE = 12'h120;
    localparam int BUDGET_DATA_COUNT = 8;

    // Field positions
    localparam int POWER_STATE_LSB = 0;
    localparam int NO_SOFT_RESET_BIT = 3;
    localparam int PME_STATUS_BIT = 15;
    localparam int BUDGET_UNLOCK_BIT = 0;

    // Power state field codes
    localparam logic [1:0] PS_CODE_D0 = 2'h0;
    localparam logic [1:0] PS_CODE_D3 = 2'h3;

    // Values after reset
    localparam logic NO_SOFT_RESET_RST = 1'b1;
    localparam logic [15:0] PME_RETRY_TIMEOUT_RST = 16'h0100;
    localparam logic [15:0] TURNOFF_ACK_TIMEOUT_RST = 16'h1000;
    localparam logic [31:0] BUDGET_HEADER_RST = 32'h0000_0000;

    // Kinds of packet presented for classification
    localparam logic [2:0] KIND_CFG0 = 3'h0;
    localparam logic [2:0] KIND_MSG_SELF = 3'h1;
    localparam logic [2:0] KIND_OTHER_REQ = 3'h2;
    localparam logic [2:0] KIND_CPL_SELF = 3'h3;
    localparam logic [2:0] KIND_CPL_PASS = 3'h4;

    // Classification answers
    localparam logic [1:0] ACT_ACCEPT = 2'h0;
    localparam logic [1:0] ACT_UNSUPPORTED = 2'h1;
    localparam logic [1:0] ACT_UNEXPECTED = 2'h2;
    localparam logic [1:0] ACT_ROUTE = 2'h3;

    typedef enum logic [1:0] {
        PSPM_D0_UNINIT = 2'b00,
        PSPM_D0_ACTIVE = 2'b01,
        PSPM_D3_HOT = 2'b10,
        PSPM_D3_COLD = 2'b11
    } pspm_dstate_e;

    typedef enum logic [1:0] {
        PSPM_AGG_IDLE = 2'b00,
        PSPM_AGG_WAIT = 2'b01,
        PSPM_AGG_DONE = 2'b10
    } pspm_agg_e;

endpackage : pspm_pkg

// *** core/pspm_core.sv ***
// Switch power management: bridge states, PME retry, fence, budget regs
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Downstream bridge state affects only its port; D3hot permits L1.
// - A D3hot port seeks L1 regardless of other ports.
// - Upstream low power plus acks aggregated puts whole device low.
// - States D0 uninit, D0 active, D3hot, D3cold; reset to uninit.
// - D3 code moves D0 active to D3hot; D0 code returns to uninit.
// - Leaving D3hot resets nothing; no-soft-reset bit reads set.
// - In D3hot, type 0 config and messages to bridge are accepted.
// - In D3hot, other primary-side requests are unsupported.
// - In D3hot, every secondary-side request is unsupported.
// - In D3hot, packet-caused errors reported; other errors dropped.
// - In D3hot, own completions unexpected; passing completions routed.
// - No PME from D3cold; downstream ports send hot-plug PME in D3hot.
// - PME resent and timer restarted until software clears status.
// - Turn-off accepted in any state and broadcast to active ports.
// - One upstream ack and L2/L3 Ready only after all ports ack.
// - Upstream packet during aggregation abandons it; later ones dropped.
// - Abandoning packet handled locally or forwarded, retraining if needed.
// - Abandon does not cancel downstream handshake; retrain before delivery.
// - Ack timeout enters L2/L3 Ready and counts as ack.
// - Back in D0 uninit after handshake, PME generation resumes.
// - Budget header reads zero unless loaded during initialisation.
// - Budget block has four standard and eight data value registers.
// - Data values writable only while unlock bit is set.
module pspm_core #(
    parameter int NDS = 3
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [NDS:0] CFG_DONE,
    input wire logic PWR_REMOVED,
    output logic [NDS:0] L1_REQ,
    output logic DEV_LOWPWR,
    input wire logic REQ_VALID,
    input wire logic [1:0] REQ_PORT,
    input wire logic REQ_SEC,
    input wire logic [2:0] REQ_KIND,
    output logic RESP_VALID,
    output logic [1:0] RESP_ACTION,
    input wire logic ERR_VALID,
    input wire logic [1:0] ERR_PORT,
    input wire logic ERR_FROM_TLP,
    output logic ERR_MSG,
    input wire logic [NDS-1:0] PME_EVENT,
    output logic [NDS-1:0] PME_SEND,
    input wire logic TURNOFF_RX,
    input wire logic [NDS-1:0] PORT_ACTIVE,
    output logic [NDS-1:0] TURNOFF_TX,
    input wire logic [NDS-1:0] ACK_RX,
    output logic [NDS-1:0] ACK_TIMEOUT,
    output logic [NDS-1:0] DS_L23,
    output logic ACK_TX,
    output logic UP_L23,
    input wire logic UP_TLP_RX,
    input wire logic UP_TLP_DS,
    input wire logic [1:0] UP_TLP_PORT,
    input wire logic [NDS-1:0] DS_LINK_L0,
    output logic SELF_HANDLE,
    output logic [NDS-1:0] DS_RETRAIN,
    output logic [NDS-1:0] DS_FORWARD,
    output logic TLP_DISCARD,
    input wire logic HDR_LOAD,
    input wire logic [31:0] HDR_DATA
);
    localparam int NP = NDS + 1;

    if (NDS < 1 || NDS > 3) begin : g_bad_nds
        $error("NDS must be 1 to 3");
    end

    // APB decode; read data is captured in the setup cycle so it is a flop
    wire acc = PSEL && PENABLE && CE;
    wire wr = acc && PWRITE;
    wire setup = PSEL && !PENABLE && CE;
    wire [1:0] pidx = PADDR[6:5];
    wire [4:0] poff = PADDR[4:0];
    wire port_hit = (PADDR[11:7] == 5'h00) && (pidx <= NDS) && !PADDR[4]
        && (PADDR[1:0] == 2'b00);
    wire bdv_hit = (PADDR[11:5] == pspm_pkg::BUDGET_DATA_VALUE_BASE[11:5])
        && (PADDR[1:0] == 2'b00);
    wire [2:0] bdv_idx = PADDR[4:2];

    wire [NP-1:0][1:0] st_w;
    wire [NP-1:0][1:0] nxt_w;
    wire [NP-1:0][31:0] rd_pmcs;
    wire [NP-1:0][15:0] pme_to_w;
    wire [NP-1:0][15:0] toa_to_w;
    wire [NP-1:0] pme_status_bit_w;
    wire [NDS-1:0] pme_send_w;
    pspm_pkg::pspm_agg_e agg, next_agg;
    wire pme_block = (agg == pspm_pkg::PSPM_AGG_DONE);

    genvar gp;
    for (gp = 0; gp < NP; gp++) begin : g_port
        pspm_pkg::pspm_dstate_e st, next_st;
        logic [15:0] pme_to;
        logic [15:0] toa_to;
        logic pme_status_bit;
        wire sel = port_hit && (pidx == 2'(gp));
        wire pmcs_wr = wr && sel && (poff == pspm_pkg::PM_CONTROL_STATUS_OFF);
        wire [1:0] ps_wr = PWDATA[pspm_pkg::POWER_STATE_LSB +: 2];
        wire [1:0] ps_rd = (st == pspm_pkg::PSPM_D3_HOT ||
            st == pspm_pkg::PSPM_D3_COLD) ? pspm_pkg::PS_CODE_D3
                                          : pspm_pkg::PS_CODE_D0;

        always_comb begin
            next_st = st;
            case (st)
                pspm_pkg::PSPM_D0_UNINIT: begin
                    if (CFG_DONE[gp])
                        next_st = pspm_pkg::PSPM_D0_ACTIVE;
                end
                pspm_pkg::PSPM_D0_ACTIVE: begin
                    if (pmcs_wr && ps_wr == pspm_pkg::PS_CODE_D3)
                        next_st = pspm_pkg::PSPM_D3_HOT;
                end
                pspm_pkg::PSPM_D3_HOT: begin
                    if (PWR_REMOVED)
                        next_st = pspm_pkg::PSPM_D3_COLD;
                    else if (pmcs_wr && ps_wr == pspm_pkg::PS_CODE_D0)
                        next_st = pspm_pkg::PSPM_D0_UNINIT;
                end
                pspm_pkg::PSPM_D3_COLD: next_st = st;
                default: next_st = pspm_pkg::PSPM_D0_UNINIT;
            endcase
        end

        // Only the state flop moves on D3hot exit; timers and PME keep context
        always_ff @(posedge MCLK or posedge RST) begin
            if (RST) begin
                st <= pspm_pkg::PSPM_D0_UNINIT;
                pme_to <= pspm_pkg::PME_RETRY_TIMEOUT_RST;
                toa_to <= pspm_pkg::TURNOFF_ACK_TIMEOUT_RST;
            end else if (CE) begin
                st <= next_st;
                if (wr && sel && poff == pspm_pkg::PME_RETRY_TIMER_OFF)
                    pme_to <= PWDATA[15:0];
                if (wr && sel && poff == pspm_pkg::TURNOFF_ACK_TIMER_OFF)
                    toa_to <= PWDATA[15:0];
            end
        end

        if (gp > 0) begin : g_pme
            logic [15:0] pme_cnt;
            logic pme_pulse;
            wire clr = pmcs_wr && PWDATA[pspm_pkg::PME_STATUS_BIT];
            wire pme_ok = (st != pspm_pkg::PSPM_D3_COLD)
                && !pme_block;
            wire retry = pme_status_bit && !clr && pme_ok && (pme_cnt >= pme_to);
            // An event landing on the clearing write starts a fresh message
            wire send = (PME_EVENT[gp-1] && pme_ok && (!pme_status_bit || clr)) || retry;

            always_ff @(posedge MCLK or posedge RST) begin
                if (RST) begin
                    pme_status_bit <= 1'b0;
                    pme_cnt <= 16'h0000;
                    pme_pulse <= 1'b0;
                end else if (CE) begin
                    pme_status_bit <= send || (pme_status_bit && !clr);
                    pme_cnt <= send ? 16'h0000 : pme_cnt + 16'h0001;
                    pme_pulse <= send;
                end
            end
            assign pme_send_w[gp-1] = pme_pulse;
        end else begin : g_nopme
            assign pme_status_bit = 1'b0;
        end

        assign st_w[gp] = st;
        assign nxt_w[gp] = next_st;
        assign pme_status_bit_w[gp] = pme_status_bit;
        assign pme_to_w[gp] = pme_to;
        assign toa_to_w[gp] = toa_to;
        assign rd_pmcs[gp] = (32'(pme_status_bit) << pspm_pkg::PME_STATUS_BIT)
            | (32'(pspm_pkg::NO_SOFT_RESET_RST) << pspm_pkg::NO_SOFT_RESET_BIT)
            | 32'(ps_rd);
        // Each port's L1 request looks at its own state only
        assign L1_REQ[gp] = (st == pspm_pkg::PSPM_D3_HOT);
    end
    assign PME_SEND = pme_send_w;

    // Fence protocol: ack aggregation over active downstream ports
    logic [NDS-1:0] active_q;
    logic [NDS-1:0] ack_seen;
    logic [NDS-1:0] tmo_w;
    wire all_acked = &(ack_seen | ~active_q);
    wire abandon = (agg == pspm_pkg::PSPM_AGG_WAIT) && UP_TLP_RX
        && !TURNOFF_RX;
    wire up_to_d0u = (st_w[0] == pspm_pkg::PSPM_D3_HOT)
        && (nxt_w[0] == pspm_pkg::PSPM_D0_UNINIT);
    wire tlp_live = UP_TLP_RX && (agg != pspm_pkg::PSPM_AGG_DONE);

    always_comb begin
        next_agg = agg;
        case (agg)
            pspm_pkg::PSPM_AGG_IDLE: begin
                if (TURNOFF_RX)
                    next_agg = pspm_pkg::PSPM_AGG_WAIT;
            end
            pspm_pkg::PSPM_AGG_WAIT: begin
                if (TURNOFF_RX)
                    next_agg = pspm_pkg::PSPM_AGG_WAIT;
                else if (abandon)
                    next_agg = pspm_pkg::PSPM_AGG_IDLE;
                else if (all_acked)
                    next_agg = pspm_pkg::PSPM_AGG_DONE;
            end
            pspm_pkg::PSPM_AGG_DONE: begin
                if (TURNOFF_RX)
                    next_agg = pspm_pkg::PSPM_AGG_WAIT;
                else if (up_to_d0u)
                    next_agg = pspm_pkg::PSPM_AGG_IDLE;
            end
            default: next_agg = pspm_pkg::PSPM_AGG_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            agg <= pspm_pkg::PSPM_AGG_IDLE;
            active_q <= '0;
            TURNOFF_TX <= '0;
            ACK_TX <= 1'b0;
            TLP_DISCARD <= 1'b0;
            SELF_HANDLE <= 1'b0;
        end else if (CE) begin
            agg <= next_agg;
            if (TURNOFF_RX)
                active_q <= PORT_ACTIVE;
            TURNOFF_TX <= TURNOFF_RX ? PORT_ACTIVE : '0;
            ACK_TX <= (agg == pspm_pkg::PSPM_AGG_WAIT) && !TURNOFF_RX
                && !UP_TLP_RX && all_acked;
            TLP_DISCARD <= UP_TLP_RX && !TURNOFF_RX && pme_block;
            SELF_HANDLE <= tlp_live && !UP_TLP_DS;
        end
    end
    assign UP_L23 = pme_block;
    assign DEV_LOWPWR = pme_block && st_w[0][1];

    genvar gd;
    for (gd = 0; gd < NDS; gd++) begin : g_ds
        logic [15:0] toa_cnt;
        logic ack, l23, pend, retrain, fwd, tmo;
        wire run = (agg == pspm_pkg::PSPM_AGG_WAIT) && active_q[gd]
            && !ack_seen[gd];
        wire hit = run && (toa_cnt >= toa_to_w[gd+1]);
        wire tgt = tlp_live && UP_TLP_DS && (UP_TLP_PORT == 2'(gd));
        wire go = pend && DS_LINK_L0[gd] && !l23;

        always_ff @(posedge MCLK or posedge RST) begin
            if (RST) begin
                ack <= 1'b0;
                toa_cnt <= 16'h0000;
                l23 <= 1'b0;
                pend <= 1'b0;
                retrain <= 1'b0;
                fwd <= 1'b0;
                tmo <= 1'b0;
            end else if (CE) begin
                // Late ack still counts and wins over the clearing turn-off
                ack <= ACK_RX[gd] || hit
                    || (ack && !TURNOFF_RX);
                toa_cnt <= (TURNOFF_RX || !run) ? 16'h0000
                                                : toa_cnt + 16'h0001;
                // Downstream handshake is left alone on abandon
                l23 <= ACK_RX[gd] || hit || (l23 && !tgt);
                pend <= tgt || (pend && !go);
                retrain <= tgt && l23;
                fwd <= go;
                tmo <= hit;
            end
        end
        assign ack_seen[gd] = ack;
        assign tmo_w[gd] = tmo;
        assign DS_L23[gd] = l23;
        assign DS_RETRAIN[gd] = retrain;
        assign DS_FORWARD[gd] = fwd;
    end
    assign ACK_TIMEOUT = tmo_w;

    // Packet classification and error filtering for a bridge in D3hot
    wire req_d3 = (REQ_PORT <= NDS)
        && (st_w[REQ_PORT] == pspm_pkg::PSPM_D3_HOT);
    wire err_d3 = (ERR_PORT <= NDS)
        && (st_w[ERR_PORT] == pspm_pkg::PSPM_D3_HOT);
    logic [1:0] next_action;

    always_comb begin
        next_action = pspm_pkg::ACT_ACCEPT;
        if (REQ_KIND == pspm_pkg::KIND_CPL_PASS)
            next_action = pspm_pkg::ACT_ROUTE;
        else if (req_d3 && REQ_KIND == pspm_pkg::KIND_CPL_SELF)
            next_action = pspm_pkg::ACT_UNEXPECTED;
        else if (req_d3 && REQ_SEC)
            next_action = pspm_pkg::ACT_UNSUPPORTED;
        else if (req_d3 && REQ_KIND != pspm_pkg::KIND_CFG0
                 && REQ_KIND != pspm_pkg::KIND_MSG_SELF)
            next_action = pspm_pkg::ACT_UNSUPPORTED;
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            RESP_VALID <= 1'b0;
            RESP_ACTION <= pspm_pkg::ACT_ACCEPT;
            ERR_MSG <= 1'b0;
        end else if (CE) begin
            RESP_VALID <= REQ_VALID;
            RESP_ACTION <= next_action;
            ERR_MSG <= ERR_VALID && (ERR_FROM_TLP || !err_d3);
        end
    end

    // Power budgeting registers
    logic [31:0] budget_cap_header;
    logic [31:0] budget_data_value [pspm_pkg::BUDGET_DATA_COUNT];
    logic [2:0] budget_sel;
    logic budget_data_unlock;
    wire bdv_wr = wr && bdv_hit && budget_data_unlock;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            budget_cap_header <= pspm_pkg::BUDGET_HEADER_RST;
            budget_sel <= 3'h0;
            budget_data_unlock <= 1'b0;
            for (int i = 0; i < pspm_pkg::BUDGET_DATA_COUNT; i++)
                budget_data_value[i] <= 32'h0000_0000;
        end else if (CE) begin
            if (HDR_LOAD)
                budget_cap_header <= HDR_DATA;
            if (wr && PADDR == pspm_pkg::BUDGET_DATA_SELECT_OFF)
                budget_sel <= PWDATA[2:0];
            if (wr && PADDR == pspm_pkg::SWITCH_CONTROL_OFF)
                budget_data_unlock <= PWDATA[pspm_pkg::BUDGET_UNLOCK_BIT];
            if (bdv_wr)
                budget_data_value[bdv_idx] <= PWDATA;
        end
    end

    logic [31:0] rdata;
    logic hit_any;
    always_comb begin
        rdata = 32'h0000_0000;
        hit_any = 1'b1;
        if (port_hit) begin
            case (poff)
                pspm_pkg::PM_CONTROL_STATUS_OFF: rdata = rd_pmcs[pidx];
                pspm_pkg::PME_RETRY_TIMER_OFF: rdata = 32'(pme_to_w[pidx]);
                pspm_pkg::TURNOFF_ACK_TIMER_OFF: rdata = 32'(toa_to_w[pidx]);
                pspm_pkg::PORT_STATE_OFF: rdata = 32'(st_w[pidx]);
                default: hit_any = 1'b0;
            endcase
        end else if (bdv_hit) begin
            rdata = budget_data_value[bdv_idx];
        end else begin
            case (PADDR)
                pspm_pkg::SWITCH_CONTROL_OFF: rdata = 32'(budget_data_unlock);
                pspm_pkg::BUDGET_CAP_HEADER_OFF: rdata = budget_cap_header;
                pspm_pkg::BUDGET_DATA_SELECT_OFF: rdata = 32'(budget_sel);
                pspm_pkg::BUDGET_DATA_OFF:
                    rdata = budget_data_value[budget_sel];
                pspm_pkg::BUDGET_POWER_CAP_OFF: rdata = 32'h0000_0000;
                default: hit_any = 1'b0;
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : rdata;
            PSLVERR <= !hit_any;
        end
    end
    assign PREADY = 1'b1;

    // Checks, clocked on MCLK and quiet during reset
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    wire p1_pmcs_wr = g_port[1].pmcs_wr;
    sequence s_turnoff;
        TURNOFF_RX && CE;
    endsequence
    sequence s_wait_tlp;
        agg == pspm_pkg::PSPM_AGG_WAIT && UP_TLP_RX && !TURNOFF_RX && CE;
    endsequence

    a_d3_entry_l1: assert property (p1_pmcs_wr && CE
        && st_w[1] == pspm_pkg::PSPM_D0_ACTIVE && !PWR_REMOVED
        && PWDATA[1:0] == pspm_pkg::PS_CODE_D3 |=> L1_REQ[1] && !L1_REQ[0])
        else $error("D3 write did not raise L1 request");
    a_d0_ctx_kept: assert property (p1_pmcs_wr && CE && !PWR_REMOVED
        && st_w[1] == pspm_pkg::PSPM_D3_HOT && !PWDATA[15]
        && PWDATA[1:0] == pspm_pkg::PS_CODE_D0
        |=> st_w[1] == pspm_pkg::PSPM_D0_UNINIT && $stable(pme_to_w[1]))
        else $error("D3hot exit lost state or context");
    a_cfg_activate: assert property (CE && CFG_DONE[1]
        && st_w[1] == pspm_pkg::PSPM_D0_UNINIT
        |=> st_w[1] == pspm_pkg::PSPM_D0_ACTIVE)
        else $error("Configured bridge did not become active");
    a_d3_cfg_ok: assert property (CE && REQ_VALID && req_d3 && !REQ_SEC
        && REQ_KIND == pspm_pkg::KIND_CFG0
        |=> RESP_VALID && RESP_ACTION == pspm_pkg::ACT_ACCEPT)
        else $error("Config request refused in D3hot");
    a_d3_pri_ur: assert property (CE && REQ_VALID && req_d3 && !REQ_SEC
        && REQ_KIND == pspm_pkg::KIND_OTHER_REQ
        |=> RESP_ACTION == pspm_pkg::ACT_UNSUPPORTED)
        else $error("Primary request not unsupported in D3hot");
    a_d3_sec_ur: assert property (CE && REQ_VALID && req_d3 && REQ_SEC
        && REQ_KIND == pspm_pkg::KIND_MSG_SELF
        |=> RESP_ACTION == pspm_pkg::ACT_UNSUPPORTED)
        else $error("Secondary request not unsupported in D3hot");
    a_cpl_unexp: assert property (CE && REQ_VALID && req_d3
        && REQ_KIND == pspm_pkg::KIND_CPL_SELF
        |=> RESP_ACTION == pspm_pkg::ACT_UNEXPECTED)
        else $error("Own completion not unexpected in D3hot");
    a_err_drop: assert property (CE && ERR_VALID && err_d3
        && !ERR_FROM_TLP |=> !ERR_MSG)
        else $error("Non-packet error reported in D3hot");
    a_turnoff_bcast: assert property (s_turnoff
        |=> TURNOFF_TX == $past(PORT_ACTIVE) && !ACK_TX)
        else $error("Turn-off not broadcast to active ports");
    a_ack_after_all: assert property ($rose(ACK_TX) |->
        $past(all_acked) && UP_L23 ##1 !ACK_TX)
        else $error("Upstream ack without full aggregation");
    a_abandon_idle: assert property (s_wait_tlp |=>
        agg == pspm_pkg::PSPM_AGG_IDLE && !ACK_TX)
        else $error("Aggregation not abandoned by packet");
    a_pme_status: assert property (CE && PME_SEND[0] |-> pme_status_bit_w[1])
        else $error("PME sent without status set");
    a_bdv_lock: assert property (CE && wr && bdv_hit
        && !budget_data_unlock && bdv_idx == 3'h0
        |=> $stable(budget_data_value[0]))
        else $error("Locked budget value was written");

endmodule : pspm_core
`default_nettype wire

// *** testbench/pspm_core_tb.sv ***
// Self-checking bench for the switch power management block
`timescale 1ns/10ps
`default_nettype none
module pspm_core_tb;
    logic mclk = 0, rst = 1, psel = 0, pen = 0, pw = 0, rq = 0, rsec = 0;
    logic ev = 0, etlp = 0, to_rx = 0, tlp = 0, hl = 0, pr, pe, resp_v;
    logic err_msg, lowp, ack_tx, up_l23, self_h, disc, ce = 1, tds = 0;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, prd, hd = 0;
    logic [2:0] l0 = 3'h7;
    logic [3:0] cfg = 0, l1;
    logic [2:0] kind = 0, act = 0, mute = 0, pme = 0, ack, to_tx, tmo;
    logic [2:0] ds_l23, pme_s, ret, fwd;
    logic [1:0] resp_a;
    int n_errors = 0, samples_checked = 0, cyc = 0;

    pspm_core dut (.MCLK(mclk), .RST(rst), .CE(ce), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pw), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(pr), .PSLVERR(pe), .CFG_DONE(cfg), .PWR_REMOVED(1'h0),
        .L1_REQ(l1), .DEV_LOWPWR(lowp), .REQ_VALID(rq), .REQ_PORT(2'h1),
        .REQ_SEC(rsec), .REQ_KIND(kind), .RESP_VALID(resp_v),
        .RESP_ACTION(resp_a), .ERR_VALID(ev), .ERR_PORT(2'h1),
        .ERR_FROM_TLP(etlp), .ERR_MSG(err_msg), .PME_EVENT(pme),
        .PME_SEND(pme_s), .TURNOFF_RX(to_rx), .PORT_ACTIVE(act),
        .TURNOFF_TX(to_tx), .ACK_RX(ack), .ACK_TIMEOUT(tmo), .DS_L23(ds_l23),
        .ACK_TX(ack_tx), .UP_L23(up_l23), .UP_TLP_RX(tlp), .UP_TLP_DS(tds),
        .UP_TLP_PORT(2'h0), .DS_LINK_L0(l0), .SELF_HANDLE(self_h),
        .DS_RETRAIN(ret), .DS_FORWARD(fwd), .TLP_DISCARD(disc),
        .HDR_LOAD(hl), .HDR_DATA(hd));
    pspm_ep_model ep (.MCLK(mclk), .TURNOFF_TX(to_tx), .MUTE(mute),
        .ACK_RX(ack));

    initial forever #12.5 mclk = ~mclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge mclk);
        psel <= 1'h1;
        pw <= w;
        pa <= a;
        pwd <= d;
        @(posedge mclk);
        pen <= 1'h1;
        do @(posedge mclk); while (pr !== 1'h1);
        r = prd;
        e = pe;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb

    task automatic cls(input logic s, input logic [2:0] k,
                       input logic [1:0] a, input logic ef, input logic em);
        @(posedge mclk);
        rq <= 1'h1;
        ev <= 1'h1;
        rsec <= s;
        kind <= k;
        etlp <= ef;
        @(posedge mclk);
        rq <= 1'h0;
        ev <= 1'h0;
        #1 chk({resp_v, resp_a, err_msg}, {1'h1, a, em});
    endtask : cls

    task automatic dstate;
        logic [31:0] r;
        logic e;
        cfg <= 4'hF;
        apb(1'h1, 12'h020, 32'h3, r, e);
        cfg <= 4'h0;
        apb(1'h0, 12'h02C, 32'h0, r, e);
        chk(r, 32'h2);
        chk(l1, 4'h2);
        cls(1'h0, 3'h0, 2'h0, 1'h1, 1'h1);
        cls(1'h0, 3'h1, 2'h0, 1'h0, 1'h0);
        cls(1'h0, 3'h2, 2'h1, 1'h0, 1'h0);
        cls(1'h0, 3'h3, 2'h2, 1'h1, 1'h1);
        cls(1'h0, 3'h4, 2'h3, 1'h0, 1'h0);
        cls(1'h1, 3'h2, 2'h1, 1'h0, 1'h0);
        apb(1'h1, 12'h020, 32'h0, r, e);
        apb(1'h0, 12'h02C, 32'h0, r, e);
        chk(r, 32'h0);
        apb(1'h0, 12'h020, 32'h0, r, e);
        chk(r[3], 1'h1);
    endtask : dstate

    task automatic pme_retry;
        logic [31:0] r;
        logic e;
        int n;
        apb(1'h1, 12'h024, 32'h4, r, e);
        pme <= 3'h1;
        @(posedge mclk);
        pme <= 3'h0;
        #1 n = pme_s[0];
        for (int i = 0; i < 40; i++) begin
            if (i == 20) begin
                chk(n, 5);
                apb(1'h1, 12'h020, 32'h8000, r, e);
                n = 0;
            end
            @(posedge mclk);
            #1 n += pme_s[0];
        end
        chk(n, 0);
    endtask : pme_retry

    task automatic budget;
        logic [31:0] r;
        logic e;
        apb(1'h0, 12'h104, 32'h0, r, e);
        chk(r, 32'h0);
        hd <= 32'h0001_0004;
        hl <= 1'h1;
        @(posedge mclk);
        hl <= 1'h0;
        apb(1'h0, 12'h104, 32'h0, r, e);
        chk(r, 32'h0001_0004);
        apb(1'h1, 12'h100, 32'h1, r, e);
        apb(1'h1, 12'h120, 32'hA5A5_0001, r, e);
        apb(1'h1, 12'h100, 32'h0, r, e);
        ce <= 1'h0;
        apb(1'h1, 12'h100, 32'h1, r, e);
        ce <= 1'h1;
        apb(1'h1, 12'h120, 32'h0000_FFFF, r, e);
        apb(1'h0, 12'h120, 32'h0, r, e);
        chk(r, 32'hA5A5_0001);
        apb(1'h0, 12'h1FC, 32'h0, r, e);
        chk(e, 1'h1);
    endtask : budget

    task automatic fence;
        logic [31:0] r;
        logic e;
        logic [2:0] seen;
        seen = 3'h0;
        apb(1'h1, 12'h068, 32'h4, r, e);
        apb(1'h1, 12'h000, 32'h3, r, e);
        mute <= 3'h4;
        act <= 3'h7;
        to_rx <= 1'h1;
        @(posedge mclk);
        to_rx <= 1'h0;
        #1 chk(to_tx, 3'h7);
        for (int i = 0; i < 200 && ack_tx !== 1'h1; i++) begin
            @(posedge mclk);
            #1 seen |= tmo;
        end
        chk(seen, 3'h4);
        chk(ds_l23[2], 1'h1);
        @(posedge mclk);
        #1 chk(up_l23, 1'h1);
        chk(lowp, 1'h1);
        @(posedge mclk);
        tlp <= 1'h1;
        pme <= 3'h2;
        @(posedge mclk);
        tlp <= 1'h0;
        pme <= 3'h0;
        #1 chk({disc, pme_s}, 4'h8);
        apb(1'h1, 12'h000, 32'h0, r, e);
        #1 chk(up_l23, 1'h0);
        @(posedge mclk);
        pme <= 3'h2;
        @(posedge mclk);
        pme <= 3'h0;
        #1 chk(pme_s, 3'h2);
    endtask : fence

    task automatic abandon;
        int n;
        n = 0;
        @(posedge mclk);
        to_rx <= 1'h1;
        @(posedge mclk);
        to_rx <= 1'h0;
        tlp <= 1'h1;
        @(posedge mclk);
        tlp <= 1'h0;
        #1 chk(self_h, 1'h1);
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            #1 n += ack_tx;
        end
        chk(n, 0);
        chk(up_l23, 1'h0);
        @(posedge mclk);
        tds <= 1'h1;
        tlp <= 1'h1;
        l0 <= 3'h0;
        @(posedge mclk);
        tds <= 1'h0;
        tlp <= 1'h0;
        #1 chk({ret, ds_l23[0]}, 4'h2);
        @(posedge mclk);
        l0 <= 3'h7;
        #1 chk(fwd, 3'h0);
        @(posedge mclk);
        #1 chk(fwd, 3'h1);
    endtask : abandon

    task automatic end_sim;
        $display("errors=%0d checks=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_sim;
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        dstate;
        pme_retry;
        budget;
        fence;
        abandon;
        end_sim;
    end
endmodule : pspm_core_tb
`default_nettype wire

// *** testbench/pspm_ep_model.sv ***
// Downstream endpoints: acknowledge a turn-off three cycles later
`timescale 1ns/10ps
`default_nettype none
module pspm_ep_model (
    input wire logic MCLK,
    input wire logic [2:0] TURNOFF_TX,
    input wire logic [2:0] MUTE,
    output logic [2:0] ACK_RX
);
    logic [2:0] d1 = 3'h0;
    logic [2:0] d2 = 3'h0;
    initial ACK_RX = 3'h0;
    // A muted endpoint never answers, so the port must time out
    always @(posedge MCLK) begin
        d1 <= TURNOFF_TX & ~MUTE;
        d2 <= d1;
        ACK_RX <= d2;
    end
endmodule : pspm_ep_model
`default_nettype wire
